// >>> inc/imrc_pkg.sv
// ------------------------------------------------------------------
// Shared constants of the idle mode release control block.
// ------------------------------------------------------------------
package imrc_pkg;

    // Register byte addresses on the Wishbone slave.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_EDGE = 8'h04;
    localparam logic [7:0] ADDR_OSC  = 8'h08;
    localparam logic [7:0] ADDR_ADC  = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_PORT = 8'h14;
    localparam logic [7:0] ADDR_CMD  = 8'h18;

    // Control register fields.
    localparam int CTRL_IE       = 0;
    localparam int CTRL_NMI_BUSY = 1;
    localparam int CTRL_IRQ_BUSY = 2;
    localparam int CTRL_MASK_A   = 3;
    localparam int CTRL_MASK_B   = 4;
    localparam int CTRL_MASK_W   = 5;
    localparam int CTRL_MSVC_A   = 6;
    localparam int CTRL_MSVC_B   = 7;
    localparam logic [7:0] CTRL_RESET = 8'h38;

    // Command register strobes (write only, self clearing).
    localparam int CMD_IDLE = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_RETURN_FROM_INTERRUPT_INSTR = 2;

    // Other register fields and reset values.
    localparam int OSC_EXT_CLOCK_SELECT_BIT        = 7;
    localparam int ADC_CONV_POWER  = 7;
    localparam int PORT_MODE       = 0;
    localparam int PORT_LATCH      = 1;
    localparam int PORT_DIR_IN     = 2;
    localparam logic [7:0] EDGE_RESET = 8'h00;
    localparam logic [7:0] OSC_RESET  = 8'h00;
    localparam logic [7:0] ADC_RESET  = 8'h00;
    localparam logic [2:0] PORT_RESET = 3'h5;

    // Release source indices; a lower index wins a branch.
    localparam int SRC_NMI = 0;
    localparam int SRC_A   = 1;
    localparam int SRC_B   = 2;
    localparam int SRC_W   = 3;
    localparam int NUM_SRC = 4;

    // Edge select codes, two bits per pin.
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    typedef enum logic [1:0] {
        IMRC_RUN  = 2'b00,
        IMRC_IDLE = 2'b01,
        IMRC_STOP = 2'b10
    } imrc_mode_t;

endpackage

// >>> src/imrc_core.sv
`timescale 1ns/10ps
// What this block does
// - Leave idle on the selected edge at the non-maskable interrupt pin.
// - Released by that pin and acceptable: branch to its service routine.
// - Not acceptable: resume next instruction, hold request until return.
// - External pins release idle only unmasked, macro service off, chosen edge.
// - External release with enable flag set and acceptable: branch to routine.
// - External release with enable flag clear or unacceptable: resume next.
// - Reset pin falling during idle restarts the clock oscillator.
// - Reset leaving idle keeps data memory; ordinary reset does not.
// - Standby floats address, address/data and read/write strobes.
// - Standby floats address strobe; refresh/hold pin holds fixed level.
// - Standby request with a release already pending is not entered.
// - External clock select set stops the resonator oscillator.
// - Stop with external clock select clear grounds oscillator input.
// - Control mode pin follows peripheral; port mode follows latch.
// - Watch timer interrupt also releases idle.
module imrc_core (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic      [31:0] wb_dat_o,
    input  wire logic        reset_n_pin,
    input  wire logic        nmi_pin,
    input  wire logic        ext_irq_pin_a,
    input  wire logic        ext_irq_pin_b,
    input  wire logic        watch_timer_irq,
    input  wire logic        hold_ack_in,
    input  wire logic        periph_level,
    output logic      [1:0]  standby_mode,
    output logic             sys_clk_en,
    output logic             osc_en,
    output logic             osc_in_ground,
    output logic             ram_retain,
    output logic             cpu_run,
    output logic      [3:0]  vector_req,
    output logic             resume_next,
    output logic             bus_oe_n,
    output logic             addr_strobe_oe_n,
    output logic             refresh_hold_out,
    output logic             ctl_pin_out,
    output logic             ctl_pin_oe_n,
    output logic             conv_power
);

    // --------------------------------------------------------------
    // State record
    // --------------------------------------------------------------
    typedef struct packed {
        logic                 ack;
        logic [7:0]           dat;
        imrc_pkg::imrc_mode_t mode;
        logic [7:0]           ctrl;
        logic [7:0]           edge_sel;
        logic [7:0]           osc;
        logic [7:0]           adc;
        logic [2:0]           port;
        logic [3:0]           pend;
        logic [3:0]           vec;
        logic                 woke;
        logic                 resume;
        logic                 clk_en;
        logic                 osc_en;
        logic                 x1_gnd;
        logic                 ram_keep;
        logic                 cpu_run;
        logic                 bus_oe_n;
        logic                 addr_strobe_out_oe_n;
        logic                 hold_lvl;
        logic                 pin_out;
        logic                 pin_oe_n;
        logic                 rst_prev;
    } imrc_state_t;

    imrc_state_t st;
    imrc_state_t nx;

    logic [3:0] edges;
    logic [3:0] rel;
    logic [3:0] take;
    logic [3:0] grant;
    logic       acc;
    logic       wr;
    logic       idle_wr;
    logic       stop_wr;
    logic       return_from_interrupt_instr_wr;
    logic       mask_ok;

    // Lowest index first, so the non-maskable source always wins.
    function automatic logic [3:0] first_one(input logic [3:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = imrc_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'h0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    // --------------------------------------------------------------
    // Pin edge detection
    // --------------------------------------------------------------
    // The watch timer request is a rising pulse from the timer.
    imrc_edge_det #(
        .N (imrc_pkg::NUM_SRC)
    ) u_edge (
        .mclk  (mclk),
        .reset (reset),
        .pin   ({watch_timer_irq, ext_irq_pin_b, ext_irq_pin_a, nmi_pin}),
        .sel   ({imrc_pkg::EDGE_RISE, st.edge_sel[5:0]}),
        .hit   (edges)
    );

    // --------------------------------------------------------------
    // Release qualification and acceptance
    // --------------------------------------------------------------
    always_comb begin
        rel[imrc_pkg::SRC_NMI] = edges[imrc_pkg::SRC_NMI];
        rel[imrc_pkg::SRC_A]   = edges[imrc_pkg::SRC_A]
                               & ~st.ctrl[imrc_pkg::CTRL_MASK_A]
                               & ~st.ctrl[imrc_pkg::CTRL_MSVC_A];
        rel[imrc_pkg::SRC_B]   = edges[imrc_pkg::SRC_B]
                               & ~st.ctrl[imrc_pkg::CTRL_MASK_B]
                               & ~st.ctrl[imrc_pkg::CTRL_MSVC_B];
        rel[imrc_pkg::SRC_W]   = edges[imrc_pkg::SRC_W]
                               & ~st.ctrl[imrc_pkg::CTRL_MASK_W];
        mask_ok = st.ctrl[imrc_pkg::CTRL_IE]
                & ~st.ctrl[imrc_pkg::CTRL_IRQ_BUSY];
        take[imrc_pkg::SRC_NMI] = st.pend[imrc_pkg::SRC_NMI]
                                & ~st.ctrl[imrc_pkg::CTRL_NMI_BUSY];
        take[imrc_pkg::SRC_A] = st.pend[imrc_pkg::SRC_A] & mask_ok;
        take[imrc_pkg::SRC_B] = st.pend[imrc_pkg::SRC_B] & mask_ok;
        take[imrc_pkg::SRC_W] = st.pend[imrc_pkg::SRC_W] & mask_ok;
        grant = (st.mode == imrc_pkg::IMRC_RUN) ? first_one(take) : 4'h0;
    end

    // Bus strobes: a write lands on the edge at which ack is seen.
    assign acc     = wb_cyc_i & wb_stb_i;
    assign wr      = acc & st.ack & wb_we_i & wb_sel_i[0];
    assign idle_wr = wr & (wb_adr_i == imrc_pkg::ADDR_CMD)
                   & wb_dat_i[imrc_pkg::CMD_IDLE];
    assign stop_wr = wr & (wb_adr_i == imrc_pkg::ADDR_CMD)
                   & wb_dat_i[imrc_pkg::CMD_STOP];
    assign return_from_interrupt_instr_wr = wr & (wb_adr_i == imrc_pkg::ADDR_CMD)
                   & wb_dat_i[imrc_pkg::CMD_RETURN_FROM_INTERRUPT_INSTR];

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        nx        = st;
        nx.vec    = 4'h0;
        nx.resume = 1'b0;
        nx.ack    = acc & ~st.ack;

        // Read data is captured together with ack.
        if (acc & ~st.ack) begin
            case (wb_adr_i)
                imrc_pkg::ADDR_CTRL: nx.dat = st.ctrl;
                imrc_pkg::ADDR_EDGE: nx.dat = st.edge_sel;
                imrc_pkg::ADDR_OSC:  nx.dat = st.osc;
                imrc_pkg::ADDR_ADC:  nx.dat = st.adc;
                imrc_pkg::ADDR_STAT: nx.dat = {st.ram_keep, st.osc_en,
                                               st.pend, st.mode};
                imrc_pkg::ADDR_PORT: nx.dat = {5'h00, st.port};
                default:             nx.dat = 8'h00;
            endcase
        end

        // Register writes; unmapped addresses are acked and ignored.
        if (wr) begin
            case (wb_adr_i)
                imrc_pkg::ADDR_CTRL: nx.ctrl     = wb_dat_i[7:0];
                imrc_pkg::ADDR_EDGE: nx.edge_sel = wb_dat_i[7:0];
                imrc_pkg::ADDR_OSC:  nx.osc      = wb_dat_i[7:0];
                imrc_pkg::ADDR_ADC:  nx.adc      = wb_dat_i[7:0];
                imrc_pkg::ADDR_PORT: nx.port     = wb_dat_i[2:0];
                default:             nx.port     = nx.port;
            endcase
        end

        // Return from a routine frees the non-maskable level first.
        if (return_from_interrupt_instr_wr) begin
            if (st.ctrl[imrc_pkg::CTRL_NMI_BUSY]) begin
                nx.ctrl[imrc_pkg::CTRL_NMI_BUSY] = 1'b0;
            end else begin
                nx.ctrl[imrc_pkg::CTRL_IRQ_BUSY] = 1'b0;
            end
        end

        // A granted request clears its pending bit; a new edge in the
        // same cycle sets it again, so no event is lost.
        nx.vec  = grant;
        nx.pend = (st.pend & ~grant) | rel;
        if (grant[imrc_pkg::SRC_NMI]) begin
            nx.ctrl[imrc_pkg::CTRL_NMI_BUSY] = 1'b1;
        end else if (grant != 4'h0) begin
            nx.ctrl[imrc_pkg::CTRL_IRQ_BUSY] = 1'b1;
        end

        // Mode sequencing.
        case (st.mode)
            imrc_pkg::IMRC_RUN: begin
                if (st.woke) begin
                    nx.woke   = 1'b0;
                    nx.resume = (grant == 4'h0);
                end
                if (idle_wr | stop_wr) begin
                    if ((st.pend | rel) != 4'h0) begin
                        nx.resume = (grant == 4'h0);
                    end else if (idle_wr) begin
                        nx.mode = imrc_pkg::IMRC_IDLE;
                    end else begin
                        nx.mode = imrc_pkg::IMRC_STOP;
                    end
                end
            end
            imrc_pkg::IMRC_IDLE, imrc_pkg::IMRC_STOP: begin
                if (rel != 4'h0) begin
                    nx.mode = imrc_pkg::IMRC_RUN;
                    nx.woke = 1'b1;
                end
            end
            default: nx.mode = imrc_pkg::IMRC_RUN;
        endcase

        // Pin-driven outputs follow the mode being entered.
        nx.clk_en    = (nx.mode == imrc_pkg::IMRC_RUN);
        nx.osc_en    = ~nx.osc[imrc_pkg::OSC_EXT_CLOCK_SELECT_BIT]
                     & (nx.mode != imrc_pkg::IMRC_STOP);
        nx.x1_gnd    = ~nx.osc[imrc_pkg::OSC_EXT_CLOCK_SELECT_BIT]
                     & (nx.mode == imrc_pkg::IMRC_STOP);
        nx.bus_oe_n  = (nx.mode != imrc_pkg::IMRC_RUN);
        nx.addr_strobe_out_oe_n = (nx.mode != imrc_pkg::IMRC_RUN);
        if (nx.mode == imrc_pkg::IMRC_RUN) begin
            nx.hold_lvl = hold_ack_in;
        end
        if (nx.port[imrc_pkg::PORT_MODE]) begin
            nx.pin_out  = nx.port[imrc_pkg::PORT_LATCH];
            nx.pin_oe_n = nx.port[imrc_pkg::PORT_DIR_IN];
        end else begin
            nx.pin_out  = periph_level;
            nx.pin_oe_n = 1'b0;
        end

        // Reset pin: bus, address strobe and control pin float and the oscillator restarts;
        // memory is kept only when the reset came out of idle.
        nx.rst_prev = reset_n_pin;
        nx.cpu_run  = reset_n_pin;
        if (st.rst_prev & ~reset_n_pin) begin
            nx.ram_keep = (st.mode == imrc_pkg::IMRC_IDLE);
        end
        if (~reset_n_pin) begin
            nx.mode      = imrc_pkg::IMRC_RUN;
            nx.pend      = 4'h0;
            nx.vec       = 4'h0;
            nx.woke      = 1'b0;
            nx.resume    = 1'b0;
            nx.clk_en    = 1'b1;
            nx.osc_en    = 1'b1;
            nx.x1_gnd    = 1'b0;
            nx.bus_oe_n  = 1'b1;
            nx.addr_strobe_out_oe_n = 1'b1;
            nx.pin_oe_n  = 1'b1;
        end
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st          <= '0;
            st.mode     <= imrc_pkg::IMRC_RUN;
            st.ctrl     <= imrc_pkg::CTRL_RESET;
            st.edge_sel <= imrc_pkg::EDGE_RESET;
            st.osc      <= imrc_pkg::OSC_RESET;
            st.adc      <= imrc_pkg::ADC_RESET;
            st.port     <= imrc_pkg::PORT_RESET;
            st.clk_en   <= 1'b1;
            st.osc_en   <= 1'b1;
            st.bus_oe_n <= 1'b1;
            st.addr_strobe_out_oe_n <= 1'b1;
            st.pin_oe_n <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    // Every output is a field of the state record.
    assign wb_ack_o         = st.ack;
    assign wb_dat_o         = {24'h000000, st.dat};
    assign standby_mode     = st.mode;
    assign sys_clk_en       = st.clk_en;
    assign osc_en           = st.osc_en;
    assign osc_in_ground    = st.x1_gnd;
    assign ram_retain       = st.ram_keep;
    assign cpu_run          = st.cpu_run;
    assign vector_req       = st.vec;
    assign resume_next      = st.resume;
    assign bus_oe_n         = st.bus_oe_n;
    assign addr_strobe_oe_n = st.addr_strobe_out_oe_n;
    assign refresh_hold_out = st.hold_lvl;
    assign ctl_pin_out      = st.pin_out;
    assign ctl_pin_oe_n     = st.pin_oe_n;
    assign conv_power       = st.adc[imrc_pkg::ADC_CONV_POWER];

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    a_nmi_release: assert property (
        (st.mode == imrc_pkg::IMRC_IDLE) && rel[0] && reset_n_pin
        |=> (st.mode == imrc_pkg::IMRC_RUN) && st.clk_en && st.woke)
        else $error("NMI edge did not release idle.");
    a_nmi_branch: assert property (
        (st.mode == imrc_pkg::IMRC_IDLE) && rel[0] && reset_n_pin
        && !st.ctrl[imrc_pkg::CTRL_NMI_BUSY] && !wr
        ##1 reset_n_pin |=> st.vec[0])
        else $error("Acceptable NMI release did not branch.");
    a_nmi_held: assert property (
        st.woke && st.pend[0] && st.ctrl[imrc_pkg::CTRL_NMI_BUSY]
        && reset_n_pin |=> st.resume && st.pend[0])
        else $error("Unacceptable NMI was not held pending.");
    a_masked_hold: assert property (
        (st.mode == imrc_pkg::IMRC_IDLE) && (rel == 4'h0) && reset_n_pin
        |=> st.mode == imrc_pkg::IMRC_IDLE)
        else $error("Idle left without a qualified release.");
    a_irq_branch: assert property (
        st.woke && st.pend[1] && !st.pend[0] && mask_ok && reset_n_pin
        |=> st.vec == 4'h2)
        else $error("Acceptable pin A release did not branch.");
    a_irq_resume: assert property (
        st.woke && !st.ctrl[imrc_pkg::CTRL_IE] && !st.pend[0]
        && reset_n_pin |=> st.resume && (st.vec == 4'h0))
        else $error("Release with interrupts off did not resume.");
    a_reset_osc: assert property (
        !reset_n_pin |=> st.osc_en && !st.cpu_run && st.bus_oe_n)
        else $error("Reset pin did not restart the oscillator.");
    a_ram_keep: assert property (
        $fell(reset_n_pin) && (st.mode == imrc_pkg::IMRC_IDLE)
        |=> st.ram_keep)
        else $error("Reset from idle did not keep memory.");
    a_hold_level: assert property (
        (st.mode != imrc_pkg::IMRC_RUN)
        && ($past(st.mode) != imrc_pkg::IMRC_RUN)
        |-> $stable(st.hold_lvl) && st.addr_strobe_out_oe_n && st.bus_oe_n)
        else $error("Standby pins not floated or held.");
    a_no_entry: assert property (
        idle_wr && (st.mode == imrc_pkg::IMRC_RUN)
        && ((st.pend | rel) != 4'h0) && reset_n_pin
        |=> st.mode == imrc_pkg::IMRC_RUN)
        else $error("Standby entered with a release pending.");
    a_clock_first: assert property (
        (st.vec != 4'h0) || st.resume
        |-> st.clk_en && (st.mode == imrc_pkg::IMRC_RUN))
        else $error("Branch or resume while clock stopped.");

    c_idle_branch: cover property (
        st.mode == imrc_pkg::IMRC_IDLE ##1 st.woke ##1 (st.vec != 4'h0));
    c_idle_resume: cover property (
        st.mode == imrc_pkg::IMRC_IDLE ##1 st.woke ##1 st.resume);
    c_idle_reset: cover property (
        $fell(reset_n_pin) && (st.mode == imrc_pkg::IMRC_IDLE));

endmodule

// >>> src/imrc_edge_det.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Edge detector for the release pins.
// ------------------------------------------------------------------
module imrc_edge_det #(
    parameter int N = 4
) (
    input  wire logic           mclk,
    input  wire logic           reset,
    input  wire logic [N-1:0]   pin,
    input  wire logic [2*N-1:0] sel,
    output logic      [N-1:0]   hit
);

    typedef struct packed {
        logic [N-1:0] prev;
        logic         armed;
    } imrc_edge_state_t;

    imrc_edge_state_t st;
    imrc_edge_state_t nx;

    // Decode one pin against its selected polarity.
    function automatic logic edge_hit(input logic p, input logic c,
                                      input logic [1:0] s);
        logic r;
        r = 1'b0;
        case (s)
            imrc_pkg::EDGE_FALL: r = p & ~c;
            imrc_pkg::EDGE_RISE: r = ~p & c;
            imrc_pkg::EDGE_BOTH: r = p ^ c;
            default:             r = 1'b0;
        endcase
        return r;
    endfunction

    // The first cycle after reset only learns the pin levels, so a pin
    // already high then is not taken for a rising edge.
    always_comb begin
        nx       = st;
        nx.prev  = pin;
        nx.armed = 1'b1;
        for (int i = 0; i < N; i++) begin
            hit[i] = st.armed & edge_hit(st.prev[i], pin[i], sel[2*i +: 2]);
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

endmodule

// >>> test/imrc_src_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Release pin and reset pin sources on the far side of the block.
// ------------------------------------------------------------------
module imrc_src_model #(
    parameter int RST_HOLD = 16
) (
    input  wire logic       mclk,
    input  wire logic [3:0] fire,
    input  wire logic       rst_go,
    output logic            nmi_pin,
    output logic            ext_irq_pin_a,
    output logic            ext_irq_pin_b,
    output logic            watch_timer_irq,
    output logic            reset_n_pin
);
    logic [3:0] act1_r    = 4'h0;
    logic [3:0] act2_r    = 4'h0;
    logic [3:0] act;
    int         rst_cnt_r = 0;

    // Each request is a two-cycle pulse, so a one-cycle glitch never hides.
    always_ff @(posedge mclk) begin
        act1_r <= fire;
        act2_r <= act1_r;
    end

    // Falling-edge pins idle high so that reset release shows no fall.
    assign act             = act1_r | act2_r;
    assign nmi_pin         = ~act[0];
    assign ext_irq_pin_a   = ~act[1];
    assign ext_irq_pin_b   = ~act[2];
    assign watch_timer_irq = act[3];

    // Reset is held long enough to cover oscillator settling.
    always_ff @(posedge mclk) begin
        if (rst_go) begin
            rst_cnt_r <= RST_HOLD;
        end else if (rst_cnt_r > 0) begin
            rst_cnt_r <= rst_cnt_r - 1;
        end
    end
    assign reset_n_pin = (rst_cnt_r == 0);
endmodule

// >>> test/testbench.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Self-checking bench for the idle release control block.
// ------------------------------------------------------------------
module testbench;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic        hold_ack_in = 1'b0, periph_level = 1'b0, rst_go = 1'b0;
    logic [3:0]  fire = 4'h0;
    logic        wb_ack_o, reset_n_pin, nmi_pin, ext_irq_pin_a;
    logic        ext_irq_pin_b, watch_timer_irq, sys_clk_en, osc_en;
    logic        osc_in_ground, ram_retain, cpu_run, resume_next;
    logic        bus_oe_n, addr_strobe_oe_n, refresh_hold_out;
    logic        ctl_pin_out, ctl_pin_oe_n, conv_power;
    logic [31:0] wb_dat_o;
    logic [1:0]  standby_mode;
    logic [3:0]  vector_req;
    logic [7:0]  q;
    int          fail_count = 0;
    int          checks = 0;

    imrc_core dut (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o,
        .reset_n_pin, .nmi_pin, .ext_irq_pin_a, .ext_irq_pin_b,
        .watch_timer_irq, .hold_ack_in, .periph_level, .standby_mode,
        .sys_clk_en, .osc_en, .osc_in_ground, .ram_retain, .cpu_run,
        .vector_req, .resume_next, .bus_oe_n, .addr_strobe_oe_n,
        .refresh_hold_out, .ctl_pin_out, .ctl_pin_oe_n, .conv_power);
    imrc_src_model #(.RST_HOLD(16)) src (.mclk, .fire, .rst_go,
        .nmi_pin, .ext_irq_pin_a, .ext_irq_pin_b, .watch_timer_irq,
        .reset_n_pin);

    // ------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------
    always #5 mclk = ~mclk;

    // Sampling one step after the edge lets that edge's updates land.
    task tk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
            fail_count++;
        end
    endtask

    // Classic cycle; the master waits for ack however long it takes.
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge mclk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Pulses the sources in m, if any, and checks the resume and vector outcome against e.
    task ev(input logic [3:0] m, input logic [4:0] e, input string n);
        int k;
        if (m != 4'h0) begin
            @(posedge mclk);
            fire <= m;
            @(posedge mclk);
            fire <= 4'h0;
        end
        k = 0;
        #1;
        while (vector_req === 4'h0 && resume_next === 1'b0 && k < 20) begin
            tk(1);
            k++;
        end
        chk(n, {3'h0, e}, {3'h0, resume_next, vector_req});
    endtask

    task stop_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task t_regs;
        wb(0, imrc_pkg::ADDR_CTRL, 8'h00);
        chk("ctrl", 8'h38, q);
        wb(0, imrc_pkg::ADDR_PORT, 8'h00);
        chk("port", 8'h05, q);
        wb(1, 8'h1C, 8'hFF);
        wb(0, 8'h1C, 8'h00);
        chk("unmapped", 8'h00, q);
        wb(1, imrc_pkg::ADDR_EDGE, 8'h3F);
        wb(0, imrc_pkg::ADDR_EDGE, 8'h00);
        chk("edge", 8'h3F, q);
        wb(1, imrc_pkg::ADDR_EDGE, 8'h00);
        wb(1, imrc_pkg::ADDR_ADC, 8'h80);
        tk(1);
        chk("conv", 1'b1, conv_power);
        wb(1, imrc_pkg::ADDR_ADC, 8'h00);
        wb(1, imrc_pkg::ADDR_PORT, 8'h00);
        periph_level <= 1'b1;
        tk(2);
        chk("ctl out", 1'b1, ctl_pin_out);
        chk("ctl oe", 1'b0, ctl_pin_oe_n);
        wb(1, imrc_pkg::ADDR_PORT, 8'h01);
        tk(1);
        chk("port out", 1'b0, ctl_pin_out);
    endtask

    // Idle is left by the non-maskable pin and that source is granted.
    task t_nmi;
        wb(1, imrc_pkg::ADDR_CMD, 8'h01);
        tk(1);
        hold_ack_in <= 1'b1;
        tk(1);
        chk("mode", 2'h1, standby_mode);
        chk("clk", 1'b0, sys_clk_en);
        chk("bus", 1'b1, bus_oe_n);
        chk("addr_strobe_out", 1'b1, addr_strobe_oe_n);
        chk("rfh", 1'b0, refresh_hold_out);
        ev(4'h1, 5'h01, "nmi vec");
        chk("clk on", 1'b1, sys_clk_en);
        chk("run", 2'h0, standby_mode);
    endtask

    // While its handler runs, the non-maskable request only resumes.
    task t_busy;
        wb(1, imrc_pkg::ADDR_CMD, 8'h01);
        ev(4'h1, 5'h10, "nmi held");
        wb(1, imrc_pkg::ADDR_CMD, 8'h01);
        ev(4'h0, 5'h10, "refused");
        chk("no idle", 2'h0, standby_mode);
        wb(1, imrc_pkg::ADDR_CMD, 8'h04);
        ev(4'h0, 5'h01, "nmi late");
        wb(1, imrc_pkg::ADDR_CMD, 8'h04);
    endtask

    task t_ext;
        wb(1, imrc_pkg::ADDR_CTRL, 8'h39);
        wb(1, imrc_pkg::ADDR_CMD, 8'h01);
        ev(4'h2, 5'h00, "masked");
        chk("stay", 2'h1, standby_mode);
        wb(1, imrc_pkg::ADDR_CTRL, 8'h01);
        ev(4'h6, 5'h02, "pin a");
        wb(1, imrc_pkg::ADDR_CMD, 8'h04);
        ev(4'h0, 5'h04, "pin b");
        wb(1, imrc_pkg::ADDR_CMD, 8'h04);
        wb(1, imrc_pkg::ADDR_CMD, 8'h01);
        ev(4'h8, 5'h08, "watch");
        wb(1, imrc_pkg::ADDR_CMD, 8'h04);
        wb(1, imrc_pkg::ADDR_OSC, 8'h80);
        tk(1);
        chk("ext_clock_select_bit", 1'b0, osc_en);
        wb(1, imrc_pkg::ADDR_OSC, 8'h00);
        wb(1, imrc_pkg::ADDR_CMD, 8'h02);
        tk(1);
        chk("gnd", 1'b1, osc_in_ground);
        ev(4'h1, 5'h01, "stop nmi");
        wb(1, imrc_pkg::ADDR_CMD, 8'h04);
        wb(1, imrc_pkg::ADDR_CTRL, 8'h00);
        wb(1, imrc_pkg::ADDR_CMD, 8'h01);
        ev(4'h2, 5'h10, "ie off");
        wb(0, imrc_pkg::ADDR_STAT, 8'h00);
        chk("stat", 8'h48, q);
    endtask

    // The reset pin clears pending work, then releases idle keeping memory.
    task t_rst;
        int i;
        for (i = 0; i < 2; i++) begin
            if (i == 1) wb(1, imrc_pkg::ADDR_CMD, 8'h01);
            @(posedge mclk);
            rst_go <= 1'b1;
            @(posedge mclk);
            rst_go <= 1'b0;
            tk(3);
            chk("osc", 1'b1, osc_en);
            chk("cpu", 1'b0, cpu_run);
            chk("keep", i[0], ram_retain);
            tk(18);
            chk("cpu up", 1'b1, cpu_run);
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog.
    // ------------------------------------------------------------------
    initial begin
        tk(8);
        reset <= 1'b0;
        tk(2);
        t_regs;
        t_nmi;
        t_busy;
        t_ext;
        t_rst;
        stop_test;
    end

    // The whole run takes a few hundred cycles; this is 20000 cycles, far beyond that.
    initial begin
        #200000;
        fail_count++;
        stop_test;
    end
endmodule
